/* File: mul16_defines.svh */
// Constants of the 16 x 16 multiplier: widths, field positions, reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef MUL16_DEFINES_SVH
`define MUL16_DEFINES_SVH

// Operand and product widths
`define MUL16_OPND_W      16
`define MUL16_PROD_W      32
`define MUL16_HALF_W      16

// Bit of the raw product that takes the rounding one, per format
`define MUL16_RND_BIT_FULL   15
`define MUL16_RND_BIT_SHORT  14

// Pin synchroniser depth; the last two stages must agree
`define MUL16_SYNC_STAGES 3

// Reset values
`define MUL16_HALF_RST    16'h0000
`define MUL16_OPND_RST    16'h0000

`endif

/* File: mul16_pkg.sv */
// Types shared by the multiplier datapath files.
// Assumes mul16_defines.svh is on the include path.
`include "mul16_defines.svh"

package mul16_pkg;

	// One operand with its number-format flag
	typedef struct packed {
		logic                        tc;
		logic [`MUL16_OPND_W-1:0]    val;
	} mul16_opnd_t;

	// The two product halves
	typedef struct packed {
		logic [`MUL16_HALF_W-1:0]    upper;
		logic [`MUL16_HALF_W-1:0]    lower;
	} mul16_prod_t;

	// Static control levels taken from the pins
	typedef struct packed {
		logic                        format_sel;
		logic                        bypass;
		logic                        route_sel;
		logic                        upper_en_n;
		logic                        lower_en_n;
	} mul16_ctrl_t;

endpackage : mul16_pkg

/* File: mul16_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and rising-edge pulse.
// Assumes inputs arrive from outside the clk_i domain.
`timescale 1ns/1ns
`include "mul16_defines.svh"

module mul16_pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	// Raw pin level
	input  wire logic [WIDTH-1:0] pin_i,
	// Filtered level and per-bit rising pulse
	output logic      [WIDTH-1:0] level_o,
	output logic      [WIDTH-1:0] rise_o
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] agree;
	logic [WIDTH-1:0] next_level;

	// Only the second and third stages are looked at
	assign agree      = ~(stage2 ^ stage3);
	assign next_level = (agree & stage3) | (~agree & level_o);

	// Shift chain; the filtered level moves only when stages agree
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			stage1  <= '0;
			stage2  <= '0;
			stage3  <= '0;
			level_o <= '0;
			rise_o  <= '0;
		end else begin
			stage1  <= pin_i;
			stage2  <= stage1;
			stage3  <= stage2;
			level_o <= next_level;
			rise_o  <= next_level & ~level_o;
		end
	end

endmodule : mul16_pin_sync

/* File: mul16_core.sv */
// Top of the 16 x 16 parallel multiplier with registered operands and results.
// Assumes all operand clocks and controls arrive as asynchronous pins.
`timescale 1ns/1ns
`include "mul16_defines.svh"

module mul16_core (
	// Clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       sys_rst_i,
	// Operand pins; B pins are two-way
	input  wire logic [`MUL16_OPND_W-1:0]   a_operand_i,
	input  wire logic                       a_twos_comp_flag_i,
	input  wire logic [`MUL16_OPND_W-1:0]   b_operand_i,
	input  wire logic                       b_twos_comp_flag_i,
	input  wire logic                       round_request_i,
	// Pin clocks from the host
	input  wire logic                       a_clock_i,
	input  wire logic                       b_clock_i,
	input  wire logic                       upper_clock_i,
	input  wire logic                       lower_clock_i,
	// Static controls
	input  wire logic                       product_format_select_i,
	input  wire logic                       result_register_bypass_i,
	input  wire logic                       half_route_select_i,
	input  wire logic                       upper_port_enable_n_i,
	input  wire logic                       lower_port_enable_n_i,
	// Upper output port
	output logic [`MUL16_HALF_W-1:0]        upper_port_o,
	output logic                            upper_port_oe_o,
	// Lower half driven back onto the B pins
	output logic [`MUL16_HALF_W-1:0]        b_operand_o,
	output logic                            b_operand_oe_o
);
	import mul16_pkg::*;

	// Synchronised pins
	mul16_opnd_t                 a_pin;
	mul16_opnd_t                 b_pin;
	mul16_ctrl_t                 ctrl_raw;
	mul16_ctrl_t                 ctrl;
	logic                        round_pin;
	logic [3:0]                  clk_raw;
	logic [3:0]                  clk_rise;
	logic                        a_rise;
	logic                        b_rise;
	logic                        upper_rise;
	logic                        lower_rise;

	// Captured state
	mul16_opnd_t                 a_reg;
	mul16_opnd_t                 b_reg;
	logic                        round_reg;
	mul16_prod_t                 result_reg;
	mul16_prod_t                 result_view;

	// Array path
	logic signed [`MUL16_OPND_W:0]      a_ext;
	logic signed [`MUL16_OPND_W:0]      b_ext;
	logic signed [2*`MUL16_OPND_W+1:0]  prod_wide;
	logic [`MUL16_PROD_W-1:0]           prod_raw;
	logic [`MUL16_PROD_W-1:0]           round_add;
	logic [`MUL16_PROD_W-1:0]           prod_rnd;
	mul16_prod_t                        array_out;

	// Next values
	logic [`MUL16_HALF_W-1:0]    next_upper_port;
	logic [`MUL16_HALF_W-1:0]    next_b_out;

	// Pin clocks gathered for one synchroniser
	assign clk_raw    = {a_clock_i, b_clock_i, upper_clock_i, lower_clock_i};
	assign a_rise     = clk_rise[3];
	assign b_rise     = clk_rise[2];
	assign upper_rise = clk_rise[1];
	assign lower_rise = clk_rise[0];

	// Control levels gathered for one synchroniser
	assign ctrl_raw.format_sel = product_format_select_i;
	assign ctrl_raw.bypass     = result_register_bypass_i;
	assign ctrl_raw.route_sel  = half_route_select_i;
	assign ctrl_raw.upper_en_n = upper_port_enable_n_i;
	assign ctrl_raw.lower_en_n = lower_port_enable_n_i;

	// Clock pins: filtered level unused, rise pulses drive the registers
	mul16_pin_sync #(.WIDTH(4)) u_sync_clk (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.pin_i     (clk_raw),
		.level_o   (),
		.rise_o    (clk_rise)
	);

	// Control pins
	mul16_pin_sync #(.WIDTH($bits(mul16_ctrl_t))) u_sync_ctrl (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.pin_i     (ctrl_raw),
		.level_o   (ctrl),
		.rise_o    ()
	);

	// A operand with its flag
	mul16_pin_sync #(.WIDTH($bits(mul16_opnd_t))) u_sync_a (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.pin_i     ({a_twos_comp_flag_i, a_operand_i}),
		.level_o   (a_pin),
		.rise_o    ()
	);

	// B operand with its flag
	mul16_pin_sync #(.WIDTH($bits(mul16_opnd_t))) u_sync_b (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.pin_i     ({b_twos_comp_flag_i, b_operand_i}),
		.level_o   (b_pin),
		.rise_o    ()
	);

	// Round request
	mul16_pin_sync #(.WIDTH(1)) u_sync_rnd (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.pin_i     (round_request_i),
		.level_o   (round_pin),
		.rise_o    ()
	);

	// A operand register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			a_reg <= '{tc: 1'b0, val: `MUL16_OPND_RST};
		end else if (a_rise) begin
			a_reg <= a_pin;
		end
	end

	// B operand register, on its own clock
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			b_reg <= '{tc: 1'b0, val: `MUL16_OPND_RST};
		end else if (b_rise) begin
			b_reg <= b_pin;
		end
	end

	// Round register on the OR of both operand clocks
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			round_reg <= 1'b0;
		end else if (a_rise | b_rise) begin
			round_reg <= round_pin;
		end
	end

	// Each operand extends by its own flag: sign bit if signed, zero if not
	assign a_ext = $signed({a_reg.tc & a_reg.val[`MUL16_OPND_W-1], a_reg.val});
	assign b_ext = $signed({b_reg.tc & b_reg.val[`MUL16_OPND_W-1], b_reg.val});

	// Signed 17 x 17 covers every mix of formats exactly
	assign prod_wide = a_ext * b_ext;
	assign prod_raw  = prod_wide[`MUL16_PROD_W-1:0];

	// Rounding one lands on the bit just below the upper half's LSB after formatting
	assign round_add = !round_reg ? '0 :
		ctrl.format_sel ? `MUL16_PROD_W'(1) << `MUL16_RND_BIT_FULL
		                : `MUL16_PROD_W'(1) << `MUL16_RND_BIT_SHORT;
	assign prod_rnd  = prod_raw + round_add;

	// Output format: full split, or shifted left with sign copy in lower MSB
	assign array_out.upper = ctrl.format_sel ? prod_rnd[31:16]
	                                         : prod_rnd[30:15];
	assign array_out.lower = ctrl.format_sel ? prod_rnd[15:0]
	                                         : {prod_rnd[31], prod_rnd[14:0]};

	// Result registers, each on its own clock
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			result_reg <= '{upper: `MUL16_HALF_RST, lower: `MUL16_HALF_RST};
		end else begin
			if (upper_rise) begin
				result_reg.upper <= array_out.upper;
			end
			if (lower_rise) begin
				result_reg.lower <= array_out.lower;
			end
		end
	end

	// Bypass makes both result registers transparent
	assign result_view = ctrl.bypass ? array_out : result_reg;

	// Upper port multiplexer
	assign next_upper_port = ctrl.route_sel ? result_view.lower
	                                        : result_view.upper;
	assign next_b_out      = result_view.lower;

	// Output flops and active-low enables
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			upper_port_o    <= `MUL16_HALF_RST;
			upper_port_oe_o <= 1'b0;
			b_operand_o     <= `MUL16_HALF_RST;
			b_operand_oe_o  <= 1'b0;
		end else begin
			upper_port_o    <= next_upper_port;
			upper_port_oe_o <= ~ctrl.upper_en_n;
			b_operand_o     <= next_b_out;
			b_operand_oe_o  <= ~ctrl.lower_en_n;
		end
	end

endmodule : mul16_core

/* File: mul16_core_assertions.sv */
// Port checker for the 16 x 16 multiplier.
// Assumes a bind to mul16_core and inputs that are synchronised inside it.
`timescale 1ns/1ns
`include "mul16_defines.svh"

module mul16_core_assertions (
	// Clock and reset
	input wire logic                     clk_i,
	input wire logic                     sys_rst_i,
	// Pin controls
	input wire logic                     upper_clock_i,
	input wire logic                     lower_clock_i,
	input wire logic                     product_format_select_i,
	input wire logic                     result_register_bypass_i,
	input wire logic                     half_route_select_i,
	input wire logic                     upper_port_enable_n_i,
	input wire logic                     lower_port_enable_n_i,
	// Device outputs
	input wire logic [`MUL16_HALF_W-1:0] upper_port_o,
	input wire logic                     upper_port_oe_o,
	input wire logic [`MUL16_HALF_W-1:0] b_operand_o,
	input wire logic                     b_operand_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Stretches with no result clock, no bypass and a steady format
	sequence s_low_quiet;
		(!lower_clock_i && !result_register_bypass_i && $stable(product_format_select_i))[*8];
	endsequence
	sequence s_up_quiet;
		(!upper_clock_i && !result_register_bypass_i && !half_route_select_i
			&& $stable(product_format_select_i))[*8];
	endsequence
	// Enables reach the output enables within the sync delay
	a_upper_oe_on: assert property ((!upper_port_enable_n_i)[*6] |-> upper_port_oe_o)
		else $error("upper port idle while enabled");
	a_upper_oe_off: assert property (upper_port_enable_n_i[*6] |-> !upper_port_oe_o)
		else $error("upper port driven while disabled");
	a_lower_oe_on: assert property ((!lower_port_enable_n_i)[*6] |-> b_operand_oe_o)
		else $error("B pins idle while enabled");
	a_lower_oe_off: assert property (lower_port_enable_n_i[*6] |-> !b_operand_oe_o)
		else $error("B pins driven while disabled");
	// Route high shows the lower half on the upper port
	a_route_lower_half: assert property (half_route_select_i[*8] |-> upper_port_o == b_operand_o)
		else $error("upper port differs from lower half");
	// Result halves hold without their clocks
	a_lower_holds: assert property (s_low_quiet |=> $stable(b_operand_o))
		else $error("lower half moved without its clock");
	a_upper_holds: assert property (s_up_quiet |=> $stable(upper_port_o))
		else $error("upper half moved without its clock");
	// Outputs are still clear at the first edge after reset
	a_reset_clears: assert property (disable iff (1'b0) $fell(sys_rst_i) |-> !upper_port_oe_o
		&& !b_operand_oe_o && upper_port_o == 16'h0000 && b_operand_o == 16'h0000)
		else $error("outputs not clear after reset");
endmodule : mul16_core_assertions

bind mul16_core mul16_core_assertions u_chk (.clk_i, .sys_rst_i, .upper_clock_i, .lower_clock_i,
	.product_format_select_i, .result_register_bypass_i, .half_route_select_i,
	.upper_port_enable_n_i, .lower_port_enable_n_i, .upper_port_o, .upper_port_oe_o,
	.b_operand_o, .b_operand_oe_o);

/* File: mul16_host_model.sv */
// Host model resolving the two-way B operand pins.
// Assumes the bench gives the host's data and its wish to drive.
`timescale 1ns/1ns
`include "mul16_defines.svh"

module mul16_host_model (
	// Clock
	input wire logic                     clk_i,
	// Host side
	input wire logic [`MUL16_OPND_W-1:0] host_data_i,
	input wire logic                     host_drive_i,
	// Device side
	input wire logic [`MUL16_HALF_W-1:0] dev_data_i,
	input wire logic                     dev_oe_i,
	// Resolved pins
	output logic     [`MUL16_OPND_W-1:0] pins_o
);
	logic [`MUL16_OPND_W-1:0] last;
	// Host yields to the device; floating pins flip every cycle
	always_comb begin
		if (dev_oe_i) pins_o = dev_data_i;
		else if (host_drive_i) pins_o = host_data_i;
		else pins_o = ~last;
	end
	always_ff @(posedge clk_i) last <= pins_o;
endmodule : mul16_host_model

/* File: test_mul16_core.sv */
// Self-checking bench for the 16 x 16 multiplier.
// Assumes the host model on the B pins and the bound checker.
`timescale 1ns/1ns
`include "mul16_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module test_mul16_core;
	import mul16_pkg::*;
	logic clk_i = 0, sys_rst_i = 1, ta = 0, tb = 0, rnd = 0, ca = 0, cb = 0, cu = 0, cl = 0;
	logic fmt = 1, byp = 0, rsel = 0, uen_n = 0, len_n = 1, up_oe, b_oe;
	logic [15:0] a = 16'h0000, bh = 16'h0000, up_o, b_o, pins;
	logic [15:0] va [5] = '{16'h0003, 16'hffff, 16'h8000, 16'hfffe, 16'h7fff};
	logic [15:0] vb [5] = '{16'h0005, 16'hffff, 16'h8000, 16'h1234, 16'h8001};
	logic [4:0] sa = 5'h0c, sb = 5'h14, rr = 5'h1a;
	int n_errors = 0, checks = 0, cyc = 0;

	mul16_core uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .a_operand_i(a),
		.a_twos_comp_flag_i(ta), .b_operand_i(pins), .b_twos_comp_flag_i(tb),
		.round_request_i(rnd), .a_clock_i(ca), .b_clock_i(cb), .upper_clock_i(cu),
		.lower_clock_i(cl), .product_format_select_i(fmt), .result_register_bypass_i(byp),
		.half_route_select_i(rsel), .upper_port_enable_n_i(uen_n),
		.lower_port_enable_n_i(len_n), .upper_port_o(up_o), .upper_port_oe_o(up_oe),
		.b_operand_o(b_o), .b_operand_oe_o(b_oe));
	// Host drives the B pins only while the device has them released
	mul16_host_model host (.clk_i(clk_i), .host_data_i(bh), .host_drive_i(len_n & ~b_oe),
		.dev_data_i(b_o), .dev_oe_i(b_oe), .pins_o(pins));

	always #5 clk_i = ~clk_i;

	task automatic close_out;
		$display("Mismatches %0d, comparisons %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out

	// Wait n edges, then step just past the last one
	task automatic tk(int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tk

	// Expected halves from the operands, flags, round and format
	function automatic mul16_prod_t calc(logic [15:0] x, logic sx, logic [15:0] y,
		logic sy, logic r, logic f);
		logic [31:0] p;
		p = {{16{sx & x[15]}}, x} * {{16{sy & y[15]}}, y} + (32'(r) << (f ? 15 : 14));
		return f ? p : {p[30:15], p[31], p[14:0]};
	endfunction : calc

	// Device releases B pins, host presents operands, chosen clocks pulse, device drives pins again
	task automatic load(logic [15:0] x, logic sx, logic [15:0] y, logic sy, logic r,
		logic [1:0] ck, bit res);
		len_n = 1;
		a = x;
		ta = sx;
		bh = y;
		tb = sy;
		rnd = r;
		tk(10);
		{cb, ca} = ck;
		tk(4);
		{cb, ca} = 2'b00;
		tk(4);
		{cu, cl} = {res, res};
		tk(4);
		{cu, cl} = 2'b00;
		tk(6);
		len_n = 0;
		tk(6);
	endtask : load

	// Compare both ports and the B pins against the expected halves
	task automatic cmp(mul16_prod_t x);
		`CHK(up_o, rsel ? x.lower : x.upper)
		`CHK(b_o, x.lower)
		`CHK(pins, x.lower)
		`CHK(b_oe, 1'b1)
	endtask : cmp

	// Hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			close_out();
		end
	end

	initial begin
		tk(16);
		sys_rst_i = 0;
		// Every sign mix and round, in both formats and both routes
		for (int f = 1; f >= 0; f--) begin
			for (int s = 0; s < 2; s++) begin
				for (int i = 0; i < 5; i++) begin
					fmt = f[0];
					rsel = s[0];
					load(va[i], sa[i], vb[i], sb[i], rr[i], 2'b11, 1);
					cmp(calc(va[i], sa[i], vb[i], sb[i], rr[i], fmt));
				end
			end
		end
		// Only the A clock: B keeps its old value, round clears on the A rise alone
		fmt = 1;
		rsel = 0;
		load(16'h0002, 0, 16'h5555, 1, 0, 2'b01, 1);
		cmp(calc(16'h0002, 0, 16'h8001, 1, 0, 1));
		// New A operand, only the upper result clock: lower half keeps the old product
		load(16'h0003, 0, 16'h5555, 1, 0, 2'b01, 0);
		cu = 1;
		tk(4);
		cu = 0;
		tk(8);
		`CHK(up_o, calc(16'h0003, 0, 16'h8001, 1, 0, 1).upper)
		`CHK(b_o, calc(16'h0002, 0, 16'h8001, 1, 0, 1).lower)
		// Bypass: no result clocks needed
		byp = 1;
		load(16'h1234, 0, 16'h0010, 0, 0, 2'b11, 0);
		cmp(calc(16'h1234, 0, 16'h0010, 0, 0, 1));
		// Both ports switched off
		uen_n = 1;
		len_n = 1;
		tk(6);
		`CHK(up_oe, 1'b0)
		`CHK(b_oe, 1'b0)
		close_out();
	end
endmodule : test_mul16_core
